/* File: sacc_top.sv */
`timescale 1ns/100ps
module sacc_top
	import sacc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        conv_enable_i,
	input  wire logic        burst_enable_i,
	input  wire logic        soc_i,
	input  wire logic        lpo_clk_i,
	input  wire logic        sar_done_i,
	input  wire logic [11:0] sar_data_i,
	output logic             conv_clock_o,
	output logic             sar_start_o,
	output logic      [1:0]  sar_res_o,
	output logic             input_gain_o,
	output logic             conv_complete_o,
	output logic             busy_o
);

	// *****************************************************************
	// Reset release and oscillator synchroniser
	// *****************************************************************
	logic [1:0] rst_sync;
	logic       rst_n;
	logic       lpo_meta;
	logic       lpo_sync;
	logic       lpo_last;

	assign rst_n = rst_sync[1];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lpo_meta <= 1'b0;
			lpo_sync <= 1'b0;
			lpo_last <= 1'b0;
		end else begin
			lpo_meta <= lpo_clk_i;
			lpo_sync <= lpo_meta;
			lpo_last <= lpo_sync;
		end
	end

	// *****************************************************************
	// Functions
	// *****************************************************************
	function automatic logic [6:0] rpt_total(input logic [2:0] code);
		case (code)
			3'h0:    rpt_total = 7'h01;
			3'h1:    rpt_total = 7'h04;
			3'h2:    rpt_total = 7'h08;
			3'h3:    rpt_total = 7'h10;
			3'h4:    rpt_total = 7'h20;
			default: rpt_total = 7'h40;
		endcase
	endfunction

	function automatic logic [15:0] fmt_result(input logic [15:0] acc,
		input logic [2:0] sj, input sacc_res_t res);
		logic [15:0] v;
		v = acc >> sj[1:0];
		if (sj == SJ_LEFT) begin
			case (res)
				SACC_RES_8:  v = acc << 8;
				SACC_RES_12: v = acc << 4;
				default:     v = acc << 6;
			endcase
		end
		fmt_result = v;
	endfunction

	// *****************************************************************
	// Register file
	// *****************************************************************
	logic [7:0]  clk_mode_cfg;
	logic [7:0]  acc_cfg;
	logic [15:0] acc;
	logic        burst_q;

	wire wr_cfg  = sfr_wr_i && (sfr_addr_i == CLK_MODE_CFG_ADDR);
	wire wr_acfg = sfr_wr_i && (sfr_addr_i == ACC_CFG_ADDR);
	wire wr_low  = sfr_wr_i && (sfr_addr_i == RESULT_LOW_ADDR);
	wire wr_high = sfr_wr_i && (sfr_addr_i == RESULT_HIGH_ADDR);

	wire        track_mode = clk_mode_cfg[TRACK_MODE];
	wire        acc_en     = acc_cfg[ACC_EN];
	wire [2:0]  sj_code    = acc_cfg[SJ_MSB:SJ_LSB];
	wire [2:0]  rpt_code   = acc_cfg[RPT_MSB:RPT_LSB];
	wire sacc_res_t res_sel = acc_cfg[EXT_RES] ? SACC_RES_12 :
		(clk_mode_cfg[BYTE_RES] ? SACC_RES_8 : SACC_RES_10);
	// formatting on the read path only
	wire [15:0] fmt_val    = fmt_result(acc, sj_code, res_sel);

	wire [7:0] acfg_read = {acc_cfg[EXT_RES], 1'b0, acc_cfg[SJ_MSB:0]};
	wire [7:0] next_rdata =
		(sfr_addr_i == CLK_MODE_CFG_ADDR) ? clk_mode_cfg :
		(sfr_addr_i == ACC_CFG_ADDR)      ? acfg_read :
		(sfr_addr_i == RESULT_LOW_ADDR)   ? fmt_val[7:0] :
		(sfr_addr_i == RESULT_HIGH_ADDR)  ? fmt_val[15:8] : 8'h00;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			clk_mode_cfg <= CLK_MODE_CFG_RST;
			acc_cfg      <= ACC_CFG_RST;
			sfr_rdata_o  <= 8'h00;
		end else begin
			if (wr_cfg)
				clk_mode_cfg <= sfr_wdata_i;
			if (wr_acfg)
				acc_cfg <= sfr_wdata_i;
			if (sfr_rd_i)
				sfr_rdata_o <= next_rdata;
		end
	end

	// *****************************************************************
	// Conversion clock divider
	// *****************************************************************
	sacc_clk_if clk_ifc ();

	assign clk_ifc.div      = clk_mode_cfg[DIV_MSB:DIV_LSB];
	// burst enable, oscillator source in burst
	assign clk_ifc.use_lpo  = burst_q;
	assign clk_ifc.lpo_rise = lpo_sync && !lpo_last;

	sacc_clk_div u_div (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.ifc     (clk_ifc.divider)
	);

	wire tick = clk_ifc.tick;

	// *****************************************************************
	// Conversion sequencer
	// *****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONV_REQ,
		ST_CONV_WAIT
	} sacc_state_t;

	sacc_state_t state;
	logic [1:0]  trk_cnt;
	logic [6:0]  rep_cnt;

	// Burst may start with the converter powered down; it wakes for the run.
	wire go        = soc_i && (conv_enable_i || burst_enable_i);
	wire taken     = (state == ST_IDLE) && go;
	wire done_now  = (state == ST_CONV_WAIT) && sar_done_i;
	wire last_conv = !burst_q || ((rep_cnt + 7'h01) >= rpt_total(rpt_code));
	wire first     = (rep_cnt == 7'h00);
	wire [15:0] sample = {4'h0, sar_data_i};
	// latest result or running sum, burst sum
	wire [15:0] next_acc = (burst_q ? first : !acc_en) ? sample : 16'(acc + sample);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state           <= ST_IDLE;
			trk_cnt         <= 2'h0;
			rep_cnt         <= 7'h00;
			burst_q         <= 1'b0;
			sar_start_o     <= 1'b0;
			conv_complete_o <= 1'b0;
		end else begin
			sar_start_o     <= 1'b0;
			conv_complete_o <= 1'b0;
			case (state)
				ST_IDLE: begin
					burst_q <= burst_enable_i;
					rep_cnt <= 7'h00;
					trk_cnt <= 2'h0;
					if (go)
						state <= track_mode ? ST_TRACK : ST_CONV_REQ;
				end
				ST_TRACK: begin
					if (tick) begin
						trk_cnt <= trk_cnt + 2'h1;
						if (trk_cnt == TRACK_TICKS - 2'h1)
							state <= ST_CONV_REQ;
					end
				end
				ST_CONV_REQ: begin
					if (tick) begin
						sar_start_o <= 1'b1;
						state       <= ST_CONV_WAIT;
					end
				end
				ST_CONV_WAIT: begin
					if (sar_done_i) begin
						rep_cnt <= rep_cnt + 7'h01;
						trk_cnt <= 2'h0;
						// complete after single or whole burst
						if (last_conv) begin
							conv_complete_o <= 1'b1;
							state           <= ST_IDLE;
						end else begin
							state <= track_mode ? ST_TRACK : ST_CONV_REQ;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// *****************************************************************
	// Accumulator and registered outputs
	// *****************************************************************
	// A byte write lands after any result update in the same cycle, so a
	// clearing write of zero is never undone by a finishing conversion.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc <= ACC_RST;
		end else begin
			if (done_now)
				acc <= next_acc;
			if (wr_low)
				acc[7:0] <= sfr_wdata_i;
			if (wr_high)
				acc[15:8] <= sfr_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sar_res_o    <= SACC_RES_10;
			input_gain_o <= 1'b0;
			conv_clock_o <= 1'b0;
			busy_o       <= 1'b0;
		end else begin
			sar_res_o    <= res_sel;
			input_gain_o <= clk_mode_cfg[GAIN_SEL];
			conv_clock_o <= tick;
			busy_o       <= (state != ST_IDLE);
		end
	end

	// *****************************************************************
	// Checks
	// *****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	logic [5:0] since_tick;
	logic       div_clean;
	logic [2:0] trk_seen;
	logic [6:0] starts;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			since_tick <= 6'h00;
			div_clean  <= 1'b0;
			trk_seen   <= 3'h0;
			starts     <= 7'h00;
		end else begin
			since_tick <= tick ? 6'h00 : since_tick + 6'h01;
			div_clean  <= tick ? !wr_cfg && !burst_q : div_clean && !wr_cfg && !burst_q;
			if (taken || sar_start_o)
				trk_seen <= 3'h0;
			else if (state == ST_TRACK && tick)
				trk_seen <= trk_seen + 3'h1;
			if (taken)
				starts <= 7'h00;
			else if (sar_start_o)
				starts <= starts + 7'h01;
		end
	end

	sequence s_taken_delayed;
		taken && track_mode && !wr_cfg;
	endsequence

	sequence s_taken_direct;
		taken && !track_mode;
	endsequence

	chk_div_period: assert property (
		tick && div_clean && !burst_q && !wr_cfg |-> since_tick == 6'({1'b0, clk_ifc.div}))
		else $error("conversion clock period differs from divider plus one");

	chk_lpo_source: assert property (
		tick && $past(burst_q) |-> $past(clk_ifc.lpo_rise))
		else $error("burst conversion clock not on oscillator edge");

	chk_res_byte: assert property (
		!acc_cfg[EXT_RES] && clk_mode_cfg[BYTE_RES] |=> sar_res_o == SACC_RES_8)
		else $error("byte select did not give 8-bit resolution");

	chk_res_extended: assert property (
		acc_cfg[EXT_RES] |=> sar_res_o == SACC_RES_12)
		else $error("extended enable did not give 12-bit resolution");

	chk_gain_select: assert property (
		$changed(clk_mode_cfg[GAIN_SEL]) |=> input_gain_o == $past(clk_mode_cfg[GAIN_SEL]))
		else $error("gain output does not follow gain select");

	chk_track_delay: assert property (
		s_taken_delayed |=> state == ST_TRACK [*1] ##0 (trk_seen == 3'h0))
		else $error("delayed track did not enter tracking");

	chk_track_ticks: assert property (
		sar_start_o && $past(track_mode) && !$past(wr_cfg) |-> trk_seen == 3'h3)
		else $error("conversion began before three tracking clocks");

	chk_no_track: assert property (
		s_taken_direct |=> state == ST_CONV_REQ)
		else $error("normal track mode still tracked");

	chk_accum_latest: assert property (
		done_now && !burst_q && !acc_en && !wr_low && !wr_high |=> acc == $past(sample))
		else $error("result does not hold latest conversion");

	chk_accum_sum: assert property (
		done_now && !burst_q && acc_en && !wr_low && !wr_high
			|=> acc == 16'($past(acc) + $past(sample)))
		else $error("result does not hold running sum");

	chk_ae_reads_zero: assert property (
		sfr_rd_i && sfr_addr_i == ACC_CFG_ADDR |=> sfr_rdata_o[ACC_EN] == 1'b0)
		else $error("accumulate enable did not read zero");

	chk_shift_right: assert property (
		sfr_rd_i && sfr_addr_i == RESULT_LOW_ADDR && !sj_code[2]
			|=> sfr_rdata_o == 8'($past(acc) >> $past(sj_code[1:0])))
		else $error("right-justified read wrongly shifted");

	chk_burst_count: assert property (
		conv_complete_o && $past(burst_q) |-> starts == rpt_total(rpt_code))
		else $error("burst performed wrong number of conversions");

	chk_single_done: assert property (
		done_now && !burst_q |=> conv_complete_o && state == ST_IDLE)
		else $error("single conversion did not complete");

	chk_low_load: assert property (
		wr_low |=> acc[7:0] == $past(sfr_wdata_i))
		else $error("low byte write did not load accumulator");

endmodule

/* File: sacc_pkg.sv */
package sacc_pkg;

	// *****************************************************************
	// Register offsets on the special-function register bus
	// *****************************************************************
	localparam logic [7:0] CLK_MODE_CFG_ADDR = 8'h97;
	localparam logic [7:0] ACC_CFG_ADDR      = 8'hBA;
	localparam logic [7:0] RESULT_LOW_ADDR   = 8'hBD;
	localparam logic [7:0] RESULT_HIGH_ADDR  = 8'hBE;

	// *****************************************************************
	// Reset values
	// *****************************************************************
	localparam logic [7:0]  CLK_MODE_CFG_RST = 8'hF8;
	localparam logic [7:0]  ACC_CFG_RST      = 8'h00;
	localparam logic [15:0] ACC_RST          = 16'h0000;

	// *****************************************************************
	// Field positions
	// *****************************************************************
	localparam int DIV_MSB     = 7;
	localparam int DIV_LSB     = 3;
	localparam int BYTE_RES    = 2;
	localparam int TRACK_MODE  = 1;
	localparam int GAIN_SEL    = 0;
	localparam int EXT_RES     = 7;
	localparam int ACC_EN      = 6;
	localparam int SJ_MSB      = 5;
	localparam int SJ_LSB      = 3;
	localparam int RPT_MSB     = 2;
	localparam int RPT_LSB     = 0;

	// *****************************************************************
	// Encodings and timing
	// *****************************************************************
	localparam logic [2:0] SJ_LEFT      = 3'h4;
	localparam logic [1:0] TRACK_TICKS  = 2'h3;
	localparam int         LPO_FREQ_MHZ = 20;

	typedef enum logic [1:0] {
		SACC_RES_10 = 2'h0,
		SACC_RES_8  = 2'h1,
		SACC_RES_12 = 2'h2
	} sacc_res_t;

endpackage

/* File: sacc_clk_if.sv */
`timescale 1ns/100ps
interface sacc_clk_if;
	logic [4:0] div;
	logic       use_lpo;
	logic       lpo_rise;
	logic       tick;

	modport ctrl (output div, output use_lpo, output lpo_rise, input tick);
	modport divider (input div, input use_lpo, input lpo_rise, output tick);
endinterface

/* File: sacc_clk_div.sv */
`timescale 1ns/100ps
module sacc_clk_div
	import sacc_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	sacc_clk_if.divider ifc
);

	logic [4:0] cnt;
	logic       tick_q;
	wire        src_edge;
	wire        wrap;

	assign src_edge = ifc.use_lpo ? ifc.lpo_rise : 1'b1;
	assign wrap     = src_edge && (cnt >= ifc.div);
	assign ifc.tick = tick_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt    <= 5'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= wrap;
			if (wrap)
				cnt <= 5'h00;
			else if (src_edge)
				cnt <= cnt + 5'h01;
		end
	end

endmodule

/* File: sacc_top_bench.sv */
`timescale 1ns/100ps
module sacc_top_bench;
	import sacc_pkg::*;

	logic        clk_i          = 1'b0;
	logic        rst_n_i        = 1'b0;
	logic [7:0]  sfr_addr_i     = 8'h00;
	logic        sfr_wr_i       = 1'b0;
	logic        sfr_rd_i       = 1'b0;
	logic [7:0]  sfr_wdata_i    = 8'h00;
	logic        conv_enable_i  = 1'b0;
	logic        burst_enable_i = 1'b0;
	logic        soc_i          = 1'b0;
	logic        lpo_clk_i      = 1'b0;
	logic        sar_done_i     = 1'b0;
	logic [11:0] sar_data_i     = 12'h000;
	logic [7:0]  sfr_rdata_o;
	logic        conv_clock_o;
	logic        sar_start_o;
	logic [1:0]  sar_res_o;
	logic        input_gain_o;
	logic        conv_complete_o;
	logic        busy_o;
	integer      seed           = 32'h397A54AF;
	int          miscompares    = 0;
	int          check_count    = 0;
	int          ticks;
	int          tgap;
	int          samples;
	logic [15:0] acc;
	logic [7:0]  rd;
	logic [7:0]  v;
	logic [7:0]  av;

	always #4 clk_i = ~clk_i;
	// The oscillator is free running and unrelated in phase to the system clock.
	always #25.1 lpo_clk_i = ~lpo_clk_i;

	sacc_top dut (
		.clk_i           (clk_i),
		.rst_n_i         (rst_n_i),
		.sfr_addr_i      (sfr_addr_i),
		.sfr_wr_i        (sfr_wr_i),
		.sfr_rd_i        (sfr_rd_i),
		.sfr_wdata_i     (sfr_wdata_i),
		.sfr_rdata_o     (sfr_rdata_o),
		.conv_enable_i   (conv_enable_i),
		.burst_enable_i  (burst_enable_i),
		.soc_i           (soc_i),
		.lpo_clk_i       (lpo_clk_i),
		.sar_done_i      (sar_done_i),
		.sar_data_i      (sar_data_i),
		.conv_clock_o    (conv_clock_o),
		.sar_start_o     (sar_start_o),
		.sar_res_o       (sar_res_o),
		.input_gain_o    (input_gain_o),
		.conv_complete_o (conv_complete_o),
		.busy_o          (busy_o)
	);

	// *****************************************************************
	// Checking and bus tasks
	// *****************************************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkn(input string n, input int e, input int g);
		check_count++;
		if (g != e) begin
			miscompares++;
			$display("ERROR %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	task automatic rdb(input logic [7:0] a);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge clk_i);
		sfr_rd_i <= 1'b0;
		@(negedge clk_i);
		rd = sfr_rdata_o;
	endtask

	// The expected view assumes 10-bit mode, so left justify moves by six.
	task automatic chkres(input logic [2:0] sj);
		logic [15:0] f;
		f = (sj == SJ_LEFT) ? acc << 6 : acc >> sj[1:0];
		rdb(RESULT_HIGH_ADDR);
		chk8("result high", f[15:8], rd);
		rdb(RESULT_LOW_ADDR);
		chk8("result low", f[7:0], rd);
	endtask

	// *****************************************************************
	// One run, with the bench standing in for the analog core
	// *****************************************************************
	task automatic conv(input logic burst, input logic ae, input int n);
		int          cd;
		int          cyc;
		int          tlast;
		logic        started;
		logic [11:0] d;
		cd = 0;
		tlast = -1;
		started = 1'b0;
		ticks = 0;
		tgap = 0;
		samples = 0;
		@(posedge clk_i);
		burst_enable_i <= burst;
		conv_enable_i <= ~burst;
		soc_i <= 1'b1;
		@(posedge clk_i);
		soc_i <= 1'b0;
		for (cyc = 0; cyc < 20000; cyc++) begin
			@(posedge clk_i);
			d = {2'b00, 10'($random(seed))};
			sar_data_i <= d;
			sar_done_i <= (cd == 1);
			// A second start while busy must be ignored.
			soc_i <= (sar_start_o === 1'b1 && !started);
			if (cd == 1) begin
				if ((burst && samples == 0) || (!burst && !ae)) begin
					acc = {4'h0, d};
				end else begin
					acc = acc + {4'h0, d};
				end
				samples++;
			end
			if (cd > 0) begin
				cd--;
			end
			if (conv_clock_o === 1'b1 && !started) begin
				if (tlast >= 0) begin
					tgap = cyc - tlast;
				end
				tlast = cyc;
				ticks++;
			end
			if (sar_start_o === 1'b1) begin
				if (!started) begin
					chk8("busy", 8'h01, {7'h00, busy_o});
				end
				started = 1'b1;
				cd = 3;
			end
			if (conv_complete_o === 1'b1) begin
				break;
			end
		end
		soc_i <= 1'b0;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop();
		end
		@(posedge clk_i);
		chk8("idle after run", 8'h00, {7'h00, busy_o});
		chkn("samples per run", n, samples);
	endtask

	// *****************************************************************
	// Main sequence
	// *****************************************************************
	initial begin
		int i;
		int j;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdb(CLK_MODE_CFG_ADDR);
		chk8("mode cfg reset", CLK_MODE_CFG_RST, rd);
		rdb(ACC_CFG_ADDR);
		chk8("acc cfg reset", ACC_CFG_RST, rd);
		acc = ACC_RST;
		chkres(3'h0);
		rdb(8'h55);
		chk8("unmapped read", 8'h00, rd);
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h48 : 8'($random(seed));
			// repeat count zero, no reserved codes.
			av = {v[7:6], v[5:3] % 3'h5, 3'h0};
			wr(ACC_CFG_ADDR, av);
			rdb(ACC_CFG_ADDR);
			chk8("acc cfg readback", av & 8'hBF, rd);
			wr(CLK_MODE_CFG_ADDR, v);
			rdb(CLK_MODE_CFG_ADDR);
			chk8("mode cfg readback", v, rd);
		end
		for (i = 0; i < 8; i++) begin
			wr(ACC_CFG_ADDR, {i[2], 7'h00});
			wr(CLK_MODE_CFG_ADDR, {5'h1F, i[0], 1'b0, i[1]});
			repeat (2) @(posedge clk_i);
			v = i[2] ? 8'h02 : {7'h00, i[0]};
			chk8("resolution", v, {6'h00, sar_res_o});
			chk8("gain", {7'h00, i[1]}, {7'h00, input_gain_o});
		end
		wr(ACC_CFG_ADDR, 8'h00);
		wr(CLK_MODE_CFG_ADDR, {5'h03, 3'b010});
		conv(1'b0, 1'b0, 1);
		chkn("tick gap", 4, tgap);
		chkn("tracking ticks", 1, int'(ticks >= 3));
		wr(CLK_MODE_CFG_ADDR, {5'h03, 3'b000});
		conv(1'b0, 1'b0, 1);
		chkn("immediate ticks", 1, int'(ticks <= 2));
		wr(CLK_MODE_CFG_ADDR, {5'h01, 3'b010});
		conv(1'b1, 1'b0, 1);
		// Two oscillator periods span about 12.5 system clocks.
		chkn("oscillator tick gap", 1, int'(tgap >= 10 && tgap <= 15));
		wr(CLK_MODE_CFG_ADDR, 8'h00);
		wr(RESULT_LOW_ADDR, 8'h00);
		wr(RESULT_HIGH_ADDR, 8'h00);
		acc = 16'h0000;
		wr(ACC_CFG_ADDR, 8'h40);
		repeat (3) begin
			conv(1'b0, 1'b1, 1);
			chkres(3'h0);
		end
		wr(ACC_CFG_ADDR, 8'h00);
		conv(1'b0, 1'b0, 1);
		chkres(3'h0);
		acc = 16'($random(seed));
		wr(RESULT_LOW_ADDR, acc[7:0]);
		wr(RESULT_HIGH_ADDR, acc[15:8]);
		chkres(3'h0);
		for (i = 0; i < 6; i++) begin
			wr(ACC_CFG_ADDR, {5'h00, i[2:0]});
			conv(1'b1, 1'b0, (i == 0) ? 1 : 4 << (i - 1));
			for (j = 0; j <= 4; j++) begin
				wr(ACC_CFG_ADDR, {2'b00, j[2:0], i[2:0]});
				chkres(j[2:0]);
			end
		end
		report_and_stop();
	end
endmodule
